// [macrocell_block.sv]
// The Wishbone interface to the registers and the address map are this design's own decisions.
`include "macrocell_cfg.svh"
module macrocell_block (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [11:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte enables
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic tck_i, // Test clock pin
  input wire logic tms_i, // Test mode select pin
  input wire logic tdi_i, // Test data in pin
  output logic tdo_o, // Test data out
  output logic tdo_oe_o, // Test data out enable
  input wire logic [3:0] dedicated_in_i, // Dedicated input pins
  input wire logic [3:0] io_pin_i, // I/O pin levels
  output logic [3:0] io_out_o, // I/O pin drive value
  output logic [3:0] io_oe_o, // I/O pin output enable
  input wire logic [`OTHER_FB_W-1:0] other_feedback_i, // Other feedbacks
  input wire logic cascade_input_i, // Cascade from neighbour
  output logic cascade_output_o // Cascade to neighbour
);
  import macrocell_pkg::*;

  // ==========================================================
  // Helpers
  // Product term: AND of chosen true and complemented inputs
  function automatic logic pt_eval(input logic [`PTIN_W-1:0] ins,
                                   input logic [`PTIN_W-1:0] tm,
                                   input logic [`PTIN_W-1:0] cm);
    logic used;
    used = (|tm) | (|cm);
    pt_eval = used & (&(ins | ~tm)) & (&(~ins | ~cm));
  endfunction

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // Storage
  state_s s;
  state_s next_s;
  logic [31:0] cfg_mem [`CFG_DEPTH];
  logic [`GBUS_W-1:0] gbus;
  logic [`SW_COUNT-1:0] sw;
  logic [`PTIN_W-1:0] ptin;
  logic [`PT_COUNT-1:0] pt [`MC_COUNT];
  logic [`PT_COUNT-1:0] ptu [`MC_COUNT];
  logic [`MC_COUNT-1:0] sum, xo, dval, lvl, rise, ce, ar, ap, nq, latch;
  logic [3:0] ded, pins;
  logic casc, tck_rise, tms, tdi;
  logic wb_req, wb_mem_we, tap_mem_we;
  logic [6:0] wb_idx, tap_idx;
  logic [31:0] tap_rd, ctl, sig_word;
  logic [6:0] swsel;
  logic [6:0] w;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    sum = '0;
    xo = '0;
    dval = '0;
    lvl = '0;
    rise = '0;
    ce = '0;
    ar = '0;
    ap = '0;
    nq = '0;
    latch = '0;
    ctl = '0;
    sig_word = merge({16'h0000, s.sig}, wb_dat_i, wb_sel_i);
    swsel = '0;
    w = '0;
    for (int m = 0; m < `MC_COUNT; m++) begin
      pt[m] = '0;
      ptu[m] = '0;
    end
    // Pins pass three stages; a level counts once stages two and three agree
    next_s.sy1 = {tck_i, tms_i, tdi_i, dedicated_in_i, io_pin_i};
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    next_s.stab = (s.sy2 & ~(s.sy2 ^ s.sy3)) | (s.stab & (s.sy2 ^ s.sy3));
    next_s.stab_q = s.stab;
    ded = s.stab[`SY_DED];
    pins = s.stab[`SY_IO];
    // Global bus: dedicated inputs, I/O pins, all 64 feedbacks
    gbus = {ded, pins, s.fb, other_feedback_i};
    // Switch matrix picks 40 signals, one byte selector each
    for (int k = 0; k < `SW_COUNT; k++) begin
      swsel = cfg_mem[`CFG_SW_BASE + 7'(k / 4)][(k % 4) * 8 +: `SW_IDX_W];
      sw[k] = (swsel < 7'(`GBUS_W)) ? gbus[swsel] : 1'b0;
    end
    // Regional foldback bus joins the matrix outputs
    ptin = {s.fold, sw};
    // Product terms; an empty term stays low to save power
    for (int m = 0; m < `MC_COUNT; m++) begin
      for (int p = 0; p < `PT_COUNT; p++) begin
        w = `CFG_PT_BASE + 7'((m * `PT_COUNT + p) * 3);
        ptu[m][p] = (|cfg_mem[w]) | (|cfg_mem[w + 7'h01]) |
                    (|cfg_mem[w + 7'h02]);
        pt[m][p] = pt_eval(ptin,
          {cfg_mem[w + 7'h02][`PT_HI_TRUE], cfg_mem[w]},
          {cfg_mem[w + 7'h02][`PT_HI_COMP], cfg_mem[w + 7'h01]});
      end
    end
    // Macrocells, cascade chain ripples from the block input
    casc = cascade_input_i;
    for (int m = 0; m < `MC_COUNT; m++) begin
      ctl = cfg_mem[`CFG_MC_BASE + 7'(m)];
      sum[m] = (|(pt[m] & ctl[`MC_OR_MASK])) |
               (ctl[`MC_CAS_IN] & casc);
      casc = ctl[`MC_CAS_OUT] & sum[m];
      unique case (ctl[`MC_XOR_SEL])
        `XOR_LOW: xo[m] = sum[m];
        `XOR_HIGH: xo[m] = ~sum[m];
        `XOR_PT: xo[m] = sum[m] ^ pt[m][`PT_XOR];
        `XOR_FB: xo[m] = sum[m] ^ s.q[m];
      endcase
      case (ctl[`MC_D_SEL])
        `D_PT: dval[m] = pt[m][`PT_DATA];
        `D_PIN: dval[m] = pins[m];
        default: dval[m] = xo[m];
      endcase
      // Clock source and its rising edge
      if (ctl[`MC_CLK_SEL] == `CLK_PT) begin
        lvl[m] = pt[m][`PT_CLK];
        rise[m] = pt[m][`PT_CLK] & ~s.ptclk_q[m];
        ce[m] = 1'b1;
      end else begin
        lvl[m] = ded[ctl[`MC_CLK_SEL]];
        rise[m] = s.stab[4 + 32'(ctl[`MC_CLK_SEL])] &
                  ~s.stab_q[4 + 32'(ctl[`MC_CLK_SEL])];
        ce[m] = ~ctl[`MC_CE_EN] | pt[m][`PT_CLK];
      end
      next_s.ptclk_q[m] = pt[m][`PT_CLK];
      // Clear and preset sources
      unique case (ctl[`MC_AR_SEL])
        `AR_OFF: ar[m] = 1'b0;
        `AR_GLOBAL: ar[m] = ded[`GLOBAL_CLEAR_LINE_BIT];
        `AR_PT: ar[m] = pt[m][`PT_RST];
        `AR_BOTH: ar[m] = ded[`GLOBAL_CLEAR_LINE_BIT] | pt[m][`PT_RST];
      endcase
      ap[m] = ctl[`MC_AP_EN] & pt[m][`PT_SET];
      // Storage function of the chosen mode
      unique case (ctl[`MC_FF_MODE])
        `FF_D: nq[m] = dval[m];
        `FF_T: nq[m] = s.q[m] ^ dval[m];
        `FF_JK: nq[m] = (dval[m] & ~s.q[m]) |
                        (~pt[m][`PT_DATA] & s.q[m]);
        `FF_SR: nq[m] = dval[m] | (~pt[m][`PT_DATA] & s.q[m]);
      endcase
      latch[m] = ctl[`MC_LATCH];
      if (ar[m]) begin
        next_s.q[m] = 1'b0;
      end else if (ap[m]) begin
        next_s.q[m] = 1'b1;
      end else if (latch[m]) begin
        next_s.q[m] = lvl[m] ? dval[m] : s.q[m];
      end else if (rise[m] && ce[m]) begin
        next_s.q[m] = nq[m];
      end
      // Output and buried feedback, chosen independently
      next_s.pin_out[m] = ctl[`MC_OUT_REG] ? next_s.q[m] : xo[m];
      next_s.fb[m] = ctl[`MC_FB_REG] ? next_s.q[m] : xo[m];
      next_s.fold[m] = ~pt[m][ctl[`MC_FOLD_PT]];
      case (ctl[`MC_OE_SEL])
        3'h0: next_s.pin_oe[m] = ded[`OE_PIN0_BIT];
        3'h1: next_s.pin_oe[m] = ~ded[`OE_PIN0_BIT];
        3'h2: next_s.pin_oe[m] = ded[`OE_PIN1_BIT];
        3'h3: next_s.pin_oe[m] = ~ded[`OE_PIN1_BIT];
        3'h4: next_s.pin_oe[m] = pins[ctl[`MC_OE_IDX]];
        3'h5: next_s.pin_oe[m] = s.fb[ctl[`MC_OE_IDX]];
        3'h6: next_s.pin_oe[m] = 1'b1;
        default: next_s.pin_oe[m] = 1'b0;
      endcase
    end
    next_s.cascade = casc;

    // Test access port, advanced on each settled TCK rise
    tck_rise = s.stab[`SY_TCK] & ~s.stab_q[`SY_TCK];
    tms = s.stab[`SY_TMS];
    tdi = s.stab[`SY_TDI];
    tap_mem_we = 1'b0;
    tap_idx = s.dr[38:32];
    tap_rd = 32'h00000000;
    if (s.dr[39:32] == `TAP_SIG_ADDR) begin
      tap_rd = {16'h0000, s.sig};
    end else if (s.dr[39:32] == `TAP_FUSE_ADDR) begin
      tap_rd = {31'h00000000, s.fuse};
    end else if (!s.dr[39] && !s.fuse) begin
      tap_rd = cfg_mem[tap_idx];
    end
    if (tck_rise) begin
      unique case (s.tap)
        tap_reset: next_s.tap = tms ? tap_reset : tap_idle;
        tap_idle: next_s.tap = tms ? sel_dr : tap_idle;
        sel_dr: next_s.tap = tms ? sel_ir : cap_dr;
        cap_dr: next_s.tap = tms ? exit1_dr : shift_dr;
        shift_dr: next_s.tap = tms ? exit1_dr : shift_dr;
        exit1_dr: next_s.tap = tms ? upd_dr : pause_dr;
        pause_dr: next_s.tap = tms ? exit2_dr : pause_dr;
        exit2_dr: next_s.tap = tms ? upd_dr : shift_dr;
        upd_dr: next_s.tap = tms ? sel_dr : tap_idle;
        sel_ir: next_s.tap = tms ? tap_reset : cap_ir;
        cap_ir: next_s.tap = tms ? exit1_ir : shift_ir;
        shift_ir: next_s.tap = tms ? exit1_ir : shift_ir;
        exit1_ir: next_s.tap = tms ? upd_ir : pause_ir;
        pause_ir: next_s.tap = tms ? exit2_ir : pause_ir;
        exit2_ir: next_s.tap = tms ? upd_ir : shift_ir;
        upd_ir: next_s.tap = tms ? sel_dr : tap_idle;
      endcase
      // Actions of the state being left
      if (s.tap == tap_reset) begin
        next_s.ir = `IR_RESET;
      end else if (s.tap == cap_ir) begin
        next_s.ir = `IR_CAPTURE;
      end else if (s.tap == shift_ir) begin
        next_s.ir = {tdi, s.ir[3:1]};
      end else if (s.tap == cap_dr) begin
        if (s.ir == `IR_CFG) begin
          next_s.dr[31:0] = tap_rd;
        end else begin
          next_s.dr[0] = 1'b0;
        end
      end else if (s.tap == shift_dr) begin
        if (s.ir == `IR_CFG) begin
          next_s.dr = {tdi, s.dr[39:1]};
        end else begin
          next_s.dr[0] = tdi;
        end
      end else if (s.tap == upd_dr && s.ir == `IR_CFG) begin
        if (s.dr[39:32] == `TAP_SIG_ADDR) begin
          next_s.sig = s.dr[15:0];
        end else if (s.dr[39:32] == `TAP_FUSE_ADDR) begin
          next_s.fuse = s.fuse | s.dr[`CTRL_FUSE];
        end else if (!s.dr[39]) begin
          tap_mem_we = 1'b1;
        end
      end
      next_s.tdo_oe = (next_s.tap == shift_dr) || (next_s.tap == shift_ir);
      next_s.tdo = (next_s.tap == shift_ir) ? next_s.ir[0] : next_s.dr[0];
    end

    // Bus slave: one-cycle answer, zero on unmapped reads
    wb_req = wb_cyc_i & wb_stb_i & ~s.ack;
    wb_idx = wb_adr_i[8:2];
    wb_mem_we = 1'b0;
    next_s.ack = wb_req;
    if (wb_req && wb_we_i) begin
      if (wb_adr_i[11:9] == 3'h0) begin
        wb_mem_we = 1'b1;
      end else if (wb_adr_i == `OFF_CTRL && wb_sel_i[0]) begin
        next_s.fuse = next_s.fuse | wb_dat_i[`CTRL_FUSE];
      end else if (wb_adr_i == `OFF_SIG) begin
        next_s.sig = sig_word[15:0];
      end
    end
    if (wb_req && !wb_we_i) begin
      if (wb_adr_i[11:9] == 3'h0) begin
        next_s.rdata = s.fuse ? 32'h00000000 : cfg_mem[wb_idx];
      end else if (wb_adr_i == `OFF_CTRL) begin
        next_s.rdata = {31'h00000000, s.fuse};
      end else if (wb_adr_i == `OFF_SIG) begin
        next_s.rdata = {16'h0000, s.sig};
      end else if (wb_adr_i == `OFF_STAT) begin
        next_s.rdata = {16'h0000, 3'h0, s.cascade, s.pin_oe, s.fb, s.q};
      end else begin
        next_s.rdata = 32'h00000000;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.tap <= tap_reset;
      s.ir <= `IR_RESET;
      s.fuse <= `FUSE_RESET;
      s.sig <= `SIG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Configuration memory, bus and test port writers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CFG_DEPTH; i++) begin
        cfg_mem[i] <= `CFG_RESET;
      end
    end else begin
      if (wb_mem_we) begin
        cfg_mem[wb_idx] <= merge(cfg_mem[wb_idx], wb_dat_i, wb_sel_i);
      end
      if (tap_mem_we) begin
        cfg_mem[tap_idx] <= s.dr[31:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign tdo_o = s.tdo;
  assign tdo_oe_o = s.tdo_oe;
  assign io_out_o = s.pin_out;
  assign io_oe_o = s.pin_oe;
  assign cascade_output_o = s.cascade;

  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  fuse_sticky_a: assert property (s.fuse |=> s.fuse)
    else $error("protection fuse cleared");
  cfg_locked_a: assert property (
    wb_ack_o && !wb_we_i && $past(s.fuse) && wb_adr_i[11:9] == 3'h0
    |-> wb_dat_o == 32'h00000000)
    else $error("configuration read while protected");
  sig_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `OFF_SIG
    |-> wb_dat_o == {16'h0000, $past(s.sig)})
    else $error("signature read wrong");
  unused_pt_a: assert property (!ptu[0][0] |-> !pt[0][0])
    else $error("empty product term active");
  clear_wins_a: assert property (ar[0] |=> !s.q[0])
    else $error("clear did not clear");
  preset_set_a: assert property (!ar[0] && ap[0] |=> s.q[0])
    else $error("preset did not set");
  edge_only_a: assert property (
    !latch[0] && !rise[0] && !ar[0] && !ap[0] |=> $stable(s.q[0]))
    else $error("register changed without edge");
  enable_gate_a: assert property (
    !latch[0] && !ce[0] && !ar[0] && !ap[0] |=> $stable(s.q[0]))
    else $error("edge taken while enable low");
  latch_pass_a: assert property (
    latch[0] && lvl[0] && !ar[0] && !ap[0] |=> s.q[0] == $past(dval[0]))
    else $error("latch not transparent");
endmodule // macrocell_block

// [macrocell_cfg.svh]
`ifndef MACROCELL_CFG_SVH
`define MACROCELL_CFG_SVH
// ==========================================================
// Sizes of the logic block
`define MC_COUNT 4
`define PT_COUNT 5
`define SW_COUNT 40
`define PTIN_W 44
`define GBUS_W 72
`define OTHER_FB_W 60
`define CFG_DEPTH 128
`define SYNC_W 11
// ==========================================================
// Synchroniser bit positions
`define SY_IO 3:0
`define SY_DED 7:4
`define SY_TDI 8
`define SY_TMS 9
`define SY_TCK 10
// ==========================================================
// Configuration word map (word indices)
`define CFG_SW_BASE 7'h00
`define CFG_PT_BASE 7'h10
`define CFG_MC_BASE 7'h50
// ==========================================================
// Bus byte offsets and reset values
`define OFF_CTRL 12'h200
`define OFF_SIG 12'h204
`define OFF_STAT 12'h208
`define CTRL_FUSE 0
`define FUSE_RESET 1'h0
`define SIG_RESET 16'h0000
`define CFG_RESET 32'h00000000
// ==========================================================
// Test access port
`define IR_RESET 4'hF
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define IR_CFG 4'h2
`define TAP_FUSE_ADDR 8'h80
`define TAP_SIG_ADDR 8'h81
// ==========================================================
// Fixed product term roles inside a macrocell
`define PT_SET 0
`define PT_XOR 1
`define PT_DATA 2
`define PT_CLK 3
`define PT_RST 4
// ==========================================================
// Macrocell control word fields, product term high-word fields and selector width
`define MC_OR_MASK 4:0
`define MC_XOR_SEL 6:5
`define MC_D_SEL 8:7
`define MC_FF_MODE 10:9
`define MC_LATCH 11
`define MC_CLK_SEL 13:12
`define MC_CE_EN 14
`define MC_AR_SEL 16:15
`define MC_AP_EN 17
`define MC_OUT_REG 18
`define MC_FB_REG 19
`define MC_OE_SEL 22:20
`define MC_CAS_IN 23
`define MC_CAS_OUT 24
`define MC_FOLD_PT 27:25
`define MC_OE_IDX 29:28
`define PT_HI_TRUE 11:0
`define PT_HI_COMP 27:16
`define SW_IDX_W 7
// ==========================================================
// Field encodings
`define XOR_LOW 2'h0
`define XOR_HIGH 2'h1
`define XOR_PT 2'h2
`define XOR_FB 2'h3
`define D_XOR 2'h0
`define D_PT 2'h1
`define D_PIN 2'h2
`define FF_D 2'h0
`define FF_T 2'h1
`define FF_JK 2'h2
`define FF_SR 2'h3
`define CLK_PT 2'h3
`define AR_OFF 2'h0
`define AR_GLOBAL 2'h1
`define AR_PT 2'h2
`define AR_BOTH 2'h3
`define GLOBAL_CLEAR_LINE_BIT 3
`define OE_PIN0_BIT 2
`define OE_PIN1_BIT 3
`endif

// [macrocell_pkg.sv]
`include "macrocell_cfg.svh"
package macrocell_pkg;
  // ==========================================================
  // Test access port controller states
  typedef enum logic [15:0] {
    tap_reset = 16'h0001, tap_idle = 16'h0002, sel_dr = 16'h0004,
    cap_dr = 16'h0008, shift_dr = 16'h0010, exit1_dr = 16'h0020,
    pause_dr = 16'h0040, exit2_dr = 16'h0080, upd_dr = 16'h0100,
    sel_ir = 16'h0200, cap_ir = 16'h0400, shift_ir = 16'h0800,
    exit1_ir = 16'h1000, pause_ir = 16'h2000, exit2_ir = 16'h4000,
    upd_ir = 16'h8000
  } tap_state_e;
  // ==========================================================
  // Register state of the logic block, apart from the configuration memory
  typedef struct packed {
    logic [`SYNC_W-1:0] sy1;
    logic [`SYNC_W-1:0] sy2;
    logic [`SYNC_W-1:0] sy3;
    logic [`SYNC_W-1:0] stab;
    logic [`SYNC_W-1:0] stab_q;
    logic [`MC_COUNT-1:0] q;
    logic [`MC_COUNT-1:0] ptclk_q;
    logic [`MC_COUNT-1:0] fb;
    logic [`MC_COUNT-1:0] fold;
    logic [`MC_COUNT-1:0] pin_out;
    logic [`MC_COUNT-1:0] pin_oe;
    logic cascade;
    tap_state_e tap;
    logic [3:0] ir;
    logic [39:0] dr;
    logic tdo;
    logic tdo_oe;
    logic fuse;
    logic [15:0] sig;
    logic ack;
    logic [31:0] rdata;
  } state_s;
endpackage

// [programmable_macrocell_logic_tb.sv]
module programmable_macrocell_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tdo_o;
  logic tdo_oe_o;
  logic [3:0] dedicated_in_i = 4'h0;
  logic [3:0] io_pin_i = 4'h0;
  logic tck_i = 1'b0;
  logic tms_i = 1'b0;
  logic tdi_i = 1'b0;
  logic cascade_input_i = 1'b0;
  logic [59:0] other_feedback_i = 60'h000000000000000;
  logic [3:0] io_out_o;
  logic [3:0] io_oe_o;
  logic cascade_output_o;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic tdo_bit;
  logic [39:0] tap_out;

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  // ==========================================================
  // Design under test
  macrocell_block i_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .dedicated_in_i(dedicated_in_i), .io_pin_i(io_pin_i),
    .io_out_o(io_out_o), .io_oe_o(io_oe_o),
    .other_feedback_i(other_feedback_i),
    .cascade_input_i(cascade_input_i),
    .cascade_output_o(cascade_output_o)
  );

  // ==========================================================
  // Helpers
  // Prints the verdict and stops the run
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one result against its expected value
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One classic bus cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [11:0] adr,
                         input logic [31:0] dat, input logic [3:0] sel,
                         output logic [31:0] data);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Register write
  task automatic wr(input logic [11:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    logic [31:0] dummy;
    wb_xfer(1'b1, adr, dat, sel, dummy);
  endtask

  // Register read compared against an expected word
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h00000000, 4'hF, rd);
    check(exp, rd);
  endtask

  // Drives pins, waits out the input synchroniser, checks macrocell 0
  task automatic pins(input logic [3:0] ded, input logic exp_out,
                      input logic exp_oe);
    dedicated_in_i <= ded;
    repeat (10) @(posedge clk_i);
    check({31'h00000000, exp_out}, {31'h00000000, io_out_o[0]});
    check({31'h00000000, exp_oe}, {31'h00000000, io_oe_o[0]});
  endtask

  // One test clock: TMS and TDI change with TCK low, TDO is read
  // before the rise; each level outlasts the input synchroniser
  task automatic tck_pulse(input logic t_ms, input logic t_di,
                           output logic t_do);
    tms_i <= t_ms;
    tdi_i <= t_di;
    tck_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_do = tdo_o;
    tck_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  // Shifts n bits LSB first, TMS high on the last; keeps what TDO showed
  task automatic tap_shift(input logic [39:0] din, input int n,
                           output logic [39:0] dout);
    dout = 40'h0000000000;
    for (int i = 0; i < n; i++) begin
      tck_pulse(i == n - 1, din[i], dout[i]);
    end
  endtask

  // ==========================================================
  // Watchdog: the tests need a few thousand cycles at most
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped place
    rd_chk(12'h000, 32'h00000000);
    rd_chk(12'h200, 32'h00000000);
    rd_chk(12'h204, 32'h00000000);
    wr(12'h20C, 32'hFFFFFFFF, 4'hF);
    rd_chk(12'h20C, 32'h00000000);
    // Signature bytes merge under byte enables; config word 127 reads back
    wr(12'h204, 32'h1234ABCD, 4'h1);
    rd_chk(12'h204, 32'h000000CD);
    wr(12'h204, 32'hFFFF5678, 4'h3);
    rd_chk(12'h204, 32'h00005678);
    wr(12'h1FC, 32'hA5A5A5A5, 4'hF);
    rd_chk(12'h1FC, 32'hA5A5A5A5);
    // Selector 0 picks dedicated pin 0; term 0 of mc 0 uses it
    wr(12'h000, 32'h00000044, 4'hF);
    wr(12'h040, 32'h00000001, 4'hF);
    // Combinational output, XOR low, output enable always on
    wr(12'h140, 32'h00601001, 4'hF);
    pins(4'h1, 1'b1, 1'b1);
    pins(4'h0, 1'b0, 1'b1);
    // XOR high inverts the sum
    wr(12'h140, 32'h00601021, 4'hF);
    pins(4'h0, 1'b1, 1'b1);
    pins(4'h1, 1'b0, 1'b1);
    // Registered D, clock line 1, global clear, enable from OE pin 0
    wr(12'h140, 32'h00049001, 4'hF);
    pins(4'h0, 1'b0, 1'b0);
    pins(4'h4, 1'b0, 1'b1);
    pins(4'h5, 1'b0, 1'b1);
    pins(4'h7, 1'b1, 1'b1);
    pins(4'h6, 1'b1, 1'b1);
    pins(4'h4, 1'b1, 1'b1);
    pins(4'h6, 1'b0, 1'b1);
    pins(4'h5, 1'b0, 1'b1);
    pins(4'h7, 1'b1, 1'b1);
    pins(4'hF, 1'b0, 1'b1);
    // Data taken straight from the I/O pin
    wr(12'h140, 32'h00041101, 4'hF);
    io_pin_i <= 4'h1;
    pins(4'h4, 1'b0, 1'b1);
    pins(4'h6, 1'b1, 1'b1);
    // Status: q0 set, feedback combinational and low, all enables on
    rd_chk(12'h208, 32'h00000F01);
    // Latch passes data while clock line 1 is high, holds while low
    wr(12'h140, 32'h00041801, 4'hF);
    pins(4'h7, 1'b1, 1'b1);
    pins(4'h5, 1'b1, 1'b1);
    pins(4'h4, 1'b1, 1'b1);
    pins(4'h6, 1'b0, 1'b1);
    // Toggle mode flips on a rising edge while the term is high
    wr(12'h140, 32'h00041201, 4'hF);
    pins(4'h5, 1'b0, 1'b1);
    pins(4'h7, 1'b1, 1'b1);
    pins(4'h5, 1'b1, 1'b1);
    pins(4'h7, 1'b0, 1'b1);
    pins(4'h6, 1'b0, 1'b1);
    // Preset from term 0 sets the register without a clock edge
    wr(12'h140, 32'h00061001, 4'hF);
    pins(4'h7, 1'b1, 1'b1);
    // Selector 1 routes another macrocell's feedback into term 0
    wr(12'h140, 32'h00601001, 4'hF);
    wr(12'h040, 32'h00000002, 4'hF);
    other_feedback_i <= 60'h000000000000001;
    pins(4'h7, 1'b1, 1'b1);
    other_feedback_i <= 60'h000000000000000;
    pins(4'h7, 1'b0, 1'b1);
    // Cascade chain runs from the input through all four macrocells
    wr(12'h140, 32'h01E00000, 4'hF);
    wr(12'h144, 32'h01E00000, 4'hF);
    wr(12'h148, 32'h01E00000, 4'hF);
    wr(12'h14C, 32'h01E00000, 4'hF);
    cascade_input_i <= 1'b1;
    pins(4'h7, 1'b1, 1'b1);
    check(32'h00000001, {31'h00000000, cascade_output_o});
    cascade_input_i <= 1'b0;
    pins(4'h7, 1'b0, 1'b1);
    check(32'h00000000, {31'h00000000, cascade_output_o});
    // Test port: select config DR, read word 0 out, write word 127
    tck_pulse(1'b0, 1'b0, tdo_bit);
    tck_pulse(1'b1, 1'b0, tdo_bit);
    tck_pulse(1'b1, 1'b0, tdo_bit);
    tck_pulse(1'b0, 1'b0, tdo_bit);
    tck_pulse(1'b0, 1'b0, tdo_bit);
    tap_shift(40'h0000000002, 4, tap_out);
    tck_pulse(1'b1, 1'b0, tdo_bit);
    tck_pulse(1'b1, 1'b0, tdo_bit);
    tck_pulse(1'b0, 1'b0, tdo_bit);
    tck_pulse(1'b0, 1'b0, tdo_bit);
    check(32'h00000001, {31'h00000000, tdo_oe_o});
    tap_shift(40'h7F5A5AC3C3, 40, tap_out);
    tck_pulse(1'b1, 1'b0, tdo_bit);
    tck_pulse(1'b0, 1'b0, tdo_bit);
    check(32'h00000000, {31'h00000000, tdo_oe_o});
    check(32'h00000044, tap_out[31:0]);
    rd_chk(12'h1FC, 32'h5A5AC3C3);
    // Protection fuse: sticky, hides config, keeps signature
    wr(12'h200, 32'h00000001, 4'hF);
    rd_chk(12'h200, 32'h00000001);
    wr(12'h200, 32'h00000000, 4'hF);
    rd_chk(12'h200, 32'h00000001);
    rd_chk(12'h1FC, 32'h00000000);
    rd_chk(12'h204, 32'h00005678);
    end_sim();
  end
endmodule // programmable_macrocell_logic_tb
